// file: src/srre_defs.svh
`ifndef SRRE_DEFS_SVH
`define SRRE_DEFS_SVH
// avalon word addresses (byte offset is four times these)
`define SRRE_A_CFG 4'h0
`define SRRE_A_STAT 4'h1
`define SRRE_A_ACC 4'h2
`define SRRE_A_PSW 4'h3
`define SRRE_A_EXTENDED_STATUS_WORD 4'h4
`define SRRE_A_SP 4'h5
`define SRRE_A_PC 4'h6
`define SRRE_A_OPND 4'h7
`define SRRE_A_INSN 4'h8
`define SRRE_A_RADR 4'h9
`define SRRE_A_RDAT 4'ha
// first configuration byte fields
`define SRRE_CFG_SRC 0
`define SRRE_CFG_FRAME 2
`define SRRE_CFG_RST 8'h00
// status fields
`define SRRE_ST_ILL 0
// primary and extended status word flag positions
`define SRRE_PSW_CY 7
`define SRRE_EXTENDED_STATUS_WORD_N 5
`define SRRE_EXTENDED_STATUS_WORD_Z 1
// reset values
`define SRRE_SP_RST 16'h0007
`define SRRE_PC_RST 24'hff_0000
// opcodes and operand sub-codes
`define SRRE_OP_ESC 8'ha5
`define SRRE_OP_RET 8'h22
`define SRRE_OP_INTERRUPT_RETURN_OP 8'h32
`define SRRE_OP_RL 8'h23
`define SRRE_OP_RLC 8'h33
`define SRRE_OP_PUSHD 8'hc0
`define SRRE_OP_POPD 8'hd0
`define SRRE_OP_PUSHR 8'hca
`define SRRE_OP_POPR 8'hda
`define SRRE_SUB_BYTE 4'h8
`define SRRE_SUB_WORD 4'h9
// upper address byte of a short interrupt return
`define SRRE_PC_TOP 8'hff
// stack ram address width
`define SRRE_RAM_AW 8
`endif

// file: src/srre_pkg.sv
package srre_pkg;
  // engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ARG, ST_POP_RD, ST_POP_CAP, ST_PUSH_INC, ST_PUSH_WR} srre_state_t;
  // instruction being executed
  typedef enum logic [2:0] {OP_NONE, OP_RET, OP_INTERRUPT_RETURN_OP, OP_ROT, OP_POPD, OP_PUSHD, OP_POPR, OP_PUSHR} srre_op_t;
  // byte-enable merge of a bus write into an old value
  function automatic logic [31:0] srre_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction
endpackage

// file: src/srre_stack_ram.sv
`timescale 1ns/1ps
// stack memory: one write port, one registered read port
module srre_stack_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1]; // contents not reset, like real ram

  // write port
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // read data out of a register; same-address write returns old data
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (ce_i && re_i) begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule

// file: src/srre_rotate.sv
`timescale 1ns/1ps
// accumulator rotate left, plain or through carry
module srre_rotate (
  input wire logic [7:0] acc_i,
  input wire logic cy_i,
  input wire logic thru_i,
  output logic [7:0] res_o,
  output logic cy_o,
  output logic n_o,
  output logic z_o
);
  // bit 7 wraps to bit 0, or the old carry enters bit 0
  assign res_o = {acc_i[6:0], thru_i ? cy_i : acc_i[7]}; // RULE12 RULE14
  // carry only moves for the through-carry form
  assign cy_o = thru_i ? acc_i[7] : cy_i; // RULE13 RULE14
  assign n_o = res_o[7];
  assign z_o = (res_o == 8'h00);
endmodule

// file: src/srre_core.sv
`timescale 1ns/1ps
`include "srre_defs.svh"
// Summary of operation
// RULE1 - byte pop reads at pointer, then decrements
// RULE2 - push increments pointer, then writes ram
// RULE3 - subroutine return pops two bytes, pointer minus two
// RULE4 - subroutine return resumes at popped address
// RULE5 - frame-size bit picks two or four bytes
// RULE6 - short interrupt return targets top region
// RULE7 - short interrupt return: pointer minus two, no status
// RULE8 - long frame pops status and three-byte address
// RULE9 - long frame restores extended status only
// RULE10 - interrupt return re-arms the interrupt logic
// RULE11 - pending interrupt waits one further instruction
// RULE12 - rotate left wraps bit seven to zero
// RULE13 - plain rotate keeps carry, sets negative, zero
// RULE14 - rotate through carry swaps bit seven, carry
// RULE15 - register stack ops need escape in binary
// RULE16 - word push/pop moves pointer by two
// RULE17 - stack and return ops keep all flags; a long interrupt return here reloads the extended status word
module srre_core #(
  parameter int unsigned RAM_AW = `SRRE_RAM_AW
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic interrupt_frame_size_bit_pend_i,
  output logic interrupt_frame_size_bit_rearm_o,
  output logic interrupt_frame_size_bit_ack_o
);
  import srre_pkg::*;

  srre_state_t state_r, state_nxt; // engine state
  srre_op_t op_r, op_nxt; // current instruction
  logic [1:0] cnt_r, cnt_nxt; // byte index within a transfer
  logic [1:0] last_r, last_nxt; // index of the final byte
  logic [15:0] sp_r, sp_nxt; // stack_pointer
  logic [23:0] pc_r, pc_nxt; // program_counter
  logic [7:0] acc_r, acc_nxt; // accumulator
  logic [7:0] psw_r, psw_nxt; // primary_status_word
  logic [7:0] extended_status_word_r, extended_status_word_nxt; // extended_status_word
  logic [7:0] cfg_r, cfg_nxt; // first_configuration_byte
  logic [31:0] opnd_r, opnd_nxt; // push source, pop destination
  logic [31:0] word_r, word_nxt; // bytes gathered by a pop
  logic [RAM_AW-1:0] radr_r, radr_nxt; // software ram pointer
  logic prefix_r, prefix_nxt; // escape byte seen
  logic illegal_r; // sticky bad-encoding flag
  logic hold_r; // interrupt service held back
  logic done_r, done_nxt; // instruction completed
  logic rd2_r; // second cycle of a ram read
  logic ill_set; // bad encoding this cycle
  logic start_pop, start_push; // transfer kick-off
  logic [31:0] tmp; // merged bus write
  logic [15:0] sp_start_r; // pointer at transfer start
  logic [7:0] psw_start_r, extended_status_word_start_r; // status at transfer start
  logic [7:0] mem_rdata; // stack ram read data
  logic [7:0] rot_res; // rotate result
  logic rot_cy, rot_n, rot_z; // rotate flags

  // bus decode; every access stalls while a stack transfer runs
  wire bus_req = avs_read_i | avs_write_i;
  wire eng_busy = (state_r != ST_IDLE) && (state_r != ST_ARG);
  wire bus_take = ce_i && bus_req && avs_waitrequest_o && !eng_busy;
  wire is_rdat = (avs_address_i == `SRRE_A_RDAT);
  wire ram_first = bus_take && avs_read_i && is_rdat && !rd2_r;
  wire bus_ans = bus_take && !ram_first;
  wire bus_wr = bus_ans && avs_write_i;
  wire ibyte_stb = bus_wr && (avs_address_i == `SRRE_A_INSN) && avs_byteenable_i[0];
  wire [7:0] ibyte = avs_writedata_i[7:0];
  wire ill_clr = bus_wr && (avs_address_i == `SRRE_A_STAT) && avs_byteenable_i[0]
    && avs_writedata_i[`SRRE_ST_ILL];
  // escape is needed in binary mode, forbidden in source mode
  wire esc_ok = prefix_r ^ cfg_r[`SRRE_CFG_SRC]; // RULE15
  wire frame4 = cfg_r[`SRRE_CFG_FRAME];
  wire is_pop = (op_r == OP_POPD) || (op_r == OP_POPR);
  wire is_regop = (op_r == OP_POPR) || (op_r == OP_PUSHR);
  wire [7:0] status_w = {4'h0, eng_busy, hold_r, prefix_r, illegal_r};

  // read selection
  wire [31:0] rd_mux =
    (avs_address_i == `SRRE_A_CFG) ? {24'h00_0000, cfg_r} :
    (avs_address_i == `SRRE_A_STAT) ? {24'h00_0000, status_w} :
    (avs_address_i == `SRRE_A_ACC) ? {24'h00_0000, acc_r} :
    (avs_address_i == `SRRE_A_PSW) ? {24'h00_0000, psw_r} :
    (avs_address_i == `SRRE_A_EXTENDED_STATUS_WORD) ? {24'h00_0000, extended_status_word_r} :
    (avs_address_i == `SRRE_A_SP) ? {16'h0000, sp_r} :
    (avs_address_i == `SRRE_A_PC) ? {8'h00, pc_r} :
    (avs_address_i == `SRRE_A_OPND) ? opnd_r :
    (avs_address_i == `SRRE_A_RADR) ? 32'(radr_r) :
    is_rdat ? {24'h00_0000, mem_rdata} : 32'h0000_0000;

  // stack ram port selection; the engine owns it while busy
  wire push_wr = (state_r == ST_PUSH_WR);
  wire mem_re = ram_first || (state_r == ST_POP_RD);
  wire [RAM_AW-1:0] mem_raddr = ram_first ? radr_r : sp_r[RAM_AW-1:0];
  wire mem_we = push_wr || (bus_wr && is_rdat && avs_byteenable_i[0]);
  wire [RAM_AW-1:0] mem_waddr = push_wr ? sp_r[RAM_AW-1:0] : radr_r;
  wire [7:0] push_byte = opnd_r[{cnt_r, 3'b000} +: 8];
  wire [7:0] mem_wdata = push_wr ? push_byte : avs_writedata_i[7:0];

  // interrupt hold: set by an interrupt return, released by the next completion
  wire hold_nxt = (done_nxt && op_nxt == OP_INTERRUPT_RETURN_OP) ? 1'b1 : (done_nxt ? 1'b0 : hold_r); // RULE11

  srre_stack_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .re_i(mem_re),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  srre_rotate u_rot (
    .acc_i(acc_r),
    .cy_i(psw_r[`SRRE_PSW_CY]),
    .thru_i(ibyte[4]),
    .res_o(rot_res),
    .cy_o(rot_cy),
    .n_o(rot_n),
    .z_o(rot_z)
  );

  // next-state logic: software writes, decode, then the stack engine
  always_comb begin
    tmp = 32'h0000_0000;
    state_nxt = state_r;
    op_nxt = op_r;
    cnt_nxt = cnt_r;
    last_nxt = last_r;
    sp_nxt = sp_r;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    psw_nxt = psw_r;
    extended_status_word_nxt = extended_status_word_r;
    cfg_nxt = cfg_r;
    opnd_nxt = opnd_r;
    word_nxt = word_r;
    radr_nxt = radr_r;
    prefix_nxt = prefix_r;
    ill_set = 1'b0;
    done_nxt = 1'b0;
    start_pop = 1'b0;
    start_push = 1'b0;
    // register writes can only land in ST_IDLE or ST_ARG, never while a stack transfer runs
    if (bus_wr) begin
      case (avs_address_i)
        `SRRE_A_CFG: if (avs_byteenable_i[0]) cfg_nxt = avs_writedata_i[7:0];
        `SRRE_A_ACC: if (avs_byteenable_i[0]) acc_nxt = avs_writedata_i[7:0];
        `SRRE_A_PSW: if (avs_byteenable_i[0]) psw_nxt = avs_writedata_i[7:0];
        `SRRE_A_EXTENDED_STATUS_WORD: if (avs_byteenable_i[0]) extended_status_word_nxt = avs_writedata_i[7:0];
        `SRRE_A_RADR: if (avs_byteenable_i[0]) radr_nxt = avs_writedata_i[RAM_AW-1:0];
        `SRRE_A_SP: begin
          tmp = srre_merge({16'h0000, sp_r}, avs_writedata_i, avs_byteenable_i);
          sp_nxt = tmp[15:0];
        end
        `SRRE_A_PC: begin
          tmp = srre_merge({8'h00, pc_r}, avs_writedata_i, avs_byteenable_i);
          pc_nxt = tmp[23:0];
        end
        `SRRE_A_OPND: opnd_nxt = srre_merge(opnd_r, avs_writedata_i, avs_byteenable_i);
        default: ;
      endcase
    end
    // first instruction byte
    if (ibyte_stb && state_r == ST_IDLE) begin
      prefix_nxt = 1'b0;
      case (ibyte)
        `SRRE_OP_ESC: begin
          prefix_nxt = !prefix_r; // a doubled escape is rejected
          ill_set = prefix_r;
        end
        `SRRE_OP_RET, `SRRE_OP_INTERRUPT_RETURN_OP: begin
          if (prefix_r) begin
            ill_set = 1'b1;
          end else begin
            op_nxt = (ibyte == `SRRE_OP_RET) ? OP_RET : OP_INTERRUPT_RETURN_OP;
            // two bytes, or four with the long frame
            last_nxt = (ibyte == `SRRE_OP_INTERRUPT_RETURN_OP && frame4) ? 2'd3 : 2'd1; // RULE3 RULE5
            start_pop = 1'b1;
          end
        end
        `SRRE_OP_RL, `SRRE_OP_RLC: begin
          if (prefix_r) begin
            ill_set = 1'b1;
          end else begin
            op_nxt = OP_ROT;
            acc_nxt = rot_res; // RULE12 RULE14
            psw_nxt[`SRRE_PSW_CY] = rot_cy; // RULE13 RULE14
            extended_status_word_nxt[`SRRE_EXTENDED_STATUS_WORD_N] = rot_n; // RULE13
            extended_status_word_nxt[`SRRE_EXTENDED_STATUS_WORD_Z] = rot_z; // RULE13
            done_nxt = 1'b1;
          end
        end
        `SRRE_OP_PUSHD, `SRRE_OP_POPD: begin
          if (prefix_r) begin
            ill_set = 1'b1;
          end else begin
            op_nxt = (ibyte == `SRRE_OP_PUSHD) ? OP_PUSHD : OP_POPD;
            state_nxt = ST_ARG;
          end
        end
        `SRRE_OP_PUSHR, `SRRE_OP_POPR: begin
          if (!esc_ok) begin
            ill_set = 1'b1; // RULE15
          end else begin
            op_nxt = (ibyte == `SRRE_OP_PUSHR) ? OP_PUSHR : OP_POPR;
            state_nxt = ST_ARG;
          end
        end
        default: ill_set = 1'b1;
      endcase
    end else if (ibyte_stb && state_r == ST_ARG) begin
      // second byte: direct address (unused) or operand size code
      last_nxt = (is_regop && ibyte[3:0] == `SRRE_SUB_WORD) ? 2'd1 : 2'd0; // RULE16
      if (is_regop && ibyte[3:0] != `SRRE_SUB_BYTE && ibyte[3:0] != `SRRE_SUB_WORD) begin
        ill_set = 1'b1;
        state_nxt = ST_IDLE;
      end else if (is_pop) begin
        start_pop = 1'b1;
      end else begin
        start_push = 1'b1;
      end
    end
    // transfer kick-off; pushes send the high byte first
    if (start_pop) begin
      state_nxt = ST_POP_RD;
      cnt_nxt = 2'd0;
      word_nxt = 32'h0000_0000;
    end
    if (start_push) begin
      state_nxt = ST_PUSH_INC;
      cnt_nxt = last_nxt;
    end
    // stack engine
    case (state_r)
      ST_POP_RD: state_nxt = ST_POP_CAP; // ram read issued at current pointer
      ST_POP_CAP: begin
        // capture first, then step the pointer down
        word_nxt[{cnt_r, 3'b000} +: 8] = mem_rdata; // RULE1
        sp_nxt = sp_r - 16'h0001; // RULE1 RULE16
        cnt_nxt = cnt_r + 2'd1;
        state_nxt = ST_POP_RD;
        if (cnt_r == last_r) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
          case (op_r)
            OP_RET: pc_nxt = {pc_r[23:16], word_nxt[15:0]}; // RULE3 RULE4
            OP_INTERRUPT_RETURN_OP: begin
              if (last_r == 2'd3) begin
                pc_nxt = word_nxt[23:0]; // RULE8
                extended_status_word_nxt = word_nxt[31:24]; // RULE9
              end else begin
                pc_nxt = {`SRRE_PC_TOP, word_nxt[15:0]}; // RULE6 RULE7
              end
            end
            default: opnd_nxt = word_nxt; // RULE16
          endcase
        end
      end
      ST_PUSH_INC: begin
        sp_nxt = sp_r + 16'h0001; // RULE2 RULE16
        state_nxt = ST_PUSH_WR;
      end
      ST_PUSH_WR: begin
        // ram written at the already-raised pointer
        cnt_nxt = cnt_r - 2'd1; // RULE2
        state_nxt = ST_PUSH_INC;
        if (cnt_r == 2'd0) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: ;
    endcase
  end

  // engine registers; flags only move through rotates, long interrupt returns or software
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      cnt_r <= 2'd0;
      last_r <= 2'd0;
      sp_r <= `SRRE_SP_RST;
      pc_r <= `SRRE_PC_RST;
      acc_r <= 8'h00;
      psw_r <= 8'h00;
      extended_status_word_r <= 8'h00;
      cfg_r <= `SRRE_CFG_RST;
      opnd_r <= 32'h0000_0000;
      word_r <= 32'h0000_0000;
      radr_r <= '0;
      prefix_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
      sp_r <= sp_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      psw_r <= psw_nxt; // RULE17
      extended_status_word_r <= extended_status_word_nxt;
      cfg_r <= cfg_nxt;
      opnd_r <= opnd_nxt;
      word_r <= word_nxt;
      radr_r <= radr_nxt;
      prefix_r <= prefix_nxt;
      done_r <= done_nxt;
    end
  end

  // bus answer, sticky flag, interrupt handshake, check snapshots
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      rd2_r <= 1'b0;
      illegal_r <= 1'b0;
      hold_r <= 1'b0;
      interrupt_frame_size_bit_rearm_o <= 1'b0;
      interrupt_frame_size_bit_ack_o <= 1'b0;
      sp_start_r <= 16'h0000;
      psw_start_r <= 8'h00;
      extended_status_word_start_r <= 8'h00;
    end else if (ce_i) begin
      avs_waitrequest_o <= !bus_ans; // low for exactly one cycle per answer
      if (bus_ans && avs_read_i) avs_readdata_o <= rd_mux;
      rd2_r <= ram_first ? 1'b1 : (bus_ans ? 1'b0 : rd2_r);
      illegal_r <= (illegal_r && !ill_clr) || ill_set; // set beats clear
      hold_r <= hold_nxt; // RULE11
      interrupt_frame_size_bit_rearm_o <= done_nxt && op_nxt == OP_INTERRUPT_RETURN_OP; // RULE10
      interrupt_frame_size_bit_ack_o <= interrupt_frame_size_bit_pend_i && !hold_nxt && state_nxt == ST_IDLE; // RULE11
      if (start_pop || start_push) begin
        sp_start_r <= sp_r;
        psw_start_r <= psw_nxt;
        extended_status_word_start_r <= extended_status_word_nxt;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire [7:0] acc_rl = {acc_r[6:0], acc_r[7]};
  wire [7:0] acc_rlc = {acc_r[6:0], psw_r[`SRRE_PSW_CY]};
  wire acc_msb = acc_r[7];
  wire cy_now = psw_r[`SRRE_PSW_CY];
  wire rot_stb = ibyte_stb && state_r == ST_IDLE && !prefix_r;
  wire ret_done = done_r && op_r == OP_INTERRUPT_RETURN_OP;
  sequence s_pop_read;
    state_r == ST_POP_RD && ce_i;
  endsequence
  sequence s_pop_cap;
    state_r == ST_POP_CAP && ce_i;
  endsequence
  sequence s_push_step;
    state_r == ST_PUSH_INC && ce_i ##1 state_r == ST_PUSH_WR;
  endsequence
  property p_push_inc_first;
    s_push_step |-> sp_r == $past(sp_r) + 16'h0001 && mem_we && mem_waddr == sp_r[RAM_AW-1:0];
  endproperty
  AST_POP_READ_FIRST: assert property (s_pop_read |=> sp_r == $past(sp_r) && state_r == ST_POP_CAP) // RULE1
    else $error("pointer moved before the pop read");
  AST_POP_DEC: assert property (s_pop_cap |=> sp_r == $past(sp_r) - 16'h0001) // RULE1
    else $error("pop did not lower the pointer by one");
  AST_PUSH_ORDER: assert property (p_push_inc_first) // RULE2
    else $error("push wrote before raising the pointer");
  AST_RET_FRAME: assert property (done_r && op_r == OP_RET |-> sp_r == sp_start_r - 16'h0002
    && pc_r[15:0] == word_r[15:0]) // RULE3 RULE4
    else $error("subroutine return pointer or target wrong");
  AST_INTERRUPT_RETURN_OP_COUNT: assert property ((s_pop_read and op_r == OP_INTERRUPT_RETURN_OP) |-> last_r == (frame4 ? 2'd3 : 2'd1)) // RULE5
    else $error("interrupt return byte count ignores frame bit");
  AST_INTERRUPT_RETURN_OP_SHORT: assert property (ret_done && last_r == 2'd1 |-> sp_r == sp_start_r - 16'h0002
    && pc_r == {`SRRE_PC_TOP, word_r[15:0]} && extended_status_word_r == extended_status_word_start_r) // RULE6 RULE7
    else $error("short interrupt return wrong");
  AST_INTERRUPT_RETURN_OP_LONG: assert property (ret_done && last_r == 2'd3 |-> sp_r == sp_start_r - 16'h0004
    && pc_r == word_r[23:0] && extended_status_word_r == word_r[31:24]) // RULE8 RULE9
    else $error("long interrupt return wrong");
  AST_FLAGS_KEPT: assert property (done_r && op_r != OP_ROT |-> psw_r == psw_start_r
    && (op_r == OP_INTERRUPT_RETURN_OP || extended_status_word_r == extended_status_word_start_r)) // RULE9 RULE17
    else $error("stack instruction changed a flag");
  AST_REARM: assert property (interrupt_frame_size_bit_rearm_o == ret_done) // RULE10
    else $error("re-arm pulse not tied to interrupt return");
  // hold must still stand one cycle on unless the next instruction has already completed
  AST_ONE_MORE: assert property (ret_done |-> hold_r && !interrupt_frame_size_bit_ack_o ##1 (hold_r || done_r)) // RULE11
    else $error("interrupt serviced right after return");
  // no service grant while the hold is up
  AST_HOLD_BLOCKS: assert property (hold_r |-> !interrupt_frame_size_bit_ack_o) // RULE11
    else $error("interrupt granted while hold active");
  AST_HOLD_RELEASE: assert property (done_r && op_r != OP_INTERRUPT_RETURN_OP |-> !hold_r) // RULE11
    else $error("hold not released after next instruction");
  AST_RL: assert property (rot_stb && ibyte == `SRRE_OP_RL |=> acc_r == $past(acc_rl)
    && psw_r[`SRRE_PSW_CY] == $past(cy_now)) // RULE12 RULE13
    else $error("rotate left result or carry wrong");
  AST_RLC: assert property (rot_stb && ibyte == `SRRE_OP_RLC |=> acc_r == $past(acc_rlc)
    && psw_r[`SRRE_PSW_CY] == $past(acc_msb)) // RULE14
    else $error("rotate through carry wrong");
  AST_ESCAPE: assert property (ibyte_stb && state_r == ST_IDLE && !esc_ok
    && (ibyte == `SRRE_OP_PUSHR || ibyte == `SRRE_OP_POPR) |=> illegal_r && state_r == ST_IDLE) // RULE15
    else $error("register stack op accepted without proper escape");
  AST_WORD_PUSH: assert property (done_r && op_r == OP_PUSHR && last_r == 2'd1
    |-> sp_r == sp_start_r + 16'h0002) // RULE16
    else $error("word push moved pointer wrongly");
endmodule

// file: verif/srre_intc_model.sv
`timescale 1ns/1ps
// interrupt controller stand-in: pending level and re-arm counter
module srre_intc_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic interrupt_frame_size_bit_rearm_i,
  output logic interrupt_frame_size_bit_pend_o,
  output int rearm_cnt_o
);
  // pending follows the bench request one cycle later, like a real controller register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      interrupt_frame_size_bit_pend_o <= 1'b0;
      rearm_cnt_o <= 0;
    end else begin
      interrupt_frame_size_bit_pend_o <= req_i;
      // each re-arm pulse counted once
      if (interrupt_frame_size_bit_rearm_i === 1'b1) begin
        rearm_cnt_o <= rearm_cnt_o + 1;
      end
    end
  end
endmodule

// file: verif/srre_core_tb.sv
`timescale 1ns/1ps
`include "srre_defs.svh"
module srre_core_tb;
  logic clk_sys_i, reset_i, ce_i, avs_read_i, avs_write_i, interrupt_frame_size_bit_pend_i, pend_req;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, v;
  logic avs_waitrequest_o, interrupt_frame_size_bit_rearm_o, interrupt_frame_size_bit_ack_o, c;
  logic [7:0] a, r, primary_status_word;
  int fail_count, samples_checked, cycles, rearm_cnt;
  logic [31:0] exp_q[$]; // expected read data, oldest first

  srre_core srre_core_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .interrupt_frame_size_bit_pend_i(interrupt_frame_size_bit_pend_i), .interrupt_frame_size_bit_rearm_o(interrupt_frame_size_bit_rearm_o), .interrupt_frame_size_bit_ack_o(interrupt_frame_size_bit_ack_o));
  srre_intc_model srre_intc_model_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(pend_req),
    .interrupt_frame_size_bit_rearm_i(interrupt_frame_size_bit_rearm_o), .interrupt_frame_size_bit_pend_o(interrupt_frame_size_bit_pend_i), .rearm_cnt_o(rearm_cnt));

  // free-running 200 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one avalon transfer; idle edge first so strobes are never reassigned in one step
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    if (!w) exp_q.push_back(e);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= ad;
    avs_writedata_i <= d;
    // waitrequest sampled at each rising edge; release right after the edge that sees it low
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 200);
    if (n >= 200) fail_count++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d); bus(1'b1, ad, d, '0); endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] e); bus(1'b0, ad, '0, e); endtask
  task automatic ins(input logic [7:0] b); wr(`SRRE_A_INSN, {24'h0, b}); endtask
  task automatic ram(input logic [7:0] ad, input logic [7:0] d);
    wr(`SRRE_A_RADR, {24'h0, ad});
    wr(`SRRE_A_RDAT, {24'h0, d});
  endtask

  // watcher: every read answer takes the oldest expectation
  always @(negedge clk_sys_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      chk("readdata", exp_q.pop_front(), avs_readdata_o);
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hf;
    pend_req = 1'b0;
    void'($urandom(96358));
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(`SRRE_A_SP, 32'h0000_0007);
    rd(`SRRE_A_PC, 32'h00ff_0000);
    wr(4'hb, 32'hffff_ffff); // unmapped write dropped
    rd(4'hb, 32'h0000_0000);
    // rotates: even passes plain, odd passes through carry
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hc5 : 8'($urandom);
      primary_status_word = (i == 1) ? 8'h00 : 8'($urandom);
      c = i[0];
      wr(`SRRE_A_ACC, {24'h0, a});
      wr(`SRRE_A_PSW, {24'h0, primary_status_word});
      wr(`SRRE_A_EXTENDED_STATUS_WORD, 32'h0000_0000);
      ins(c ? `SRRE_OP_RLC : `SRRE_OP_RL);
      r = c ? {a[6:0], primary_status_word[7]} : {a[6:0], a[7]};
      rd(`SRRE_A_ACC, {24'h0, r});
      rd(`SRRE_A_PSW, {24'h0, c ? a[7] : primary_status_word[7], primary_status_word[6:0]});
      rd(`SRRE_A_EXTENDED_STATUS_WORD, {24'h0, 2'b00, r[7], 3'b000, r == 8'h00, 1'b0});
    end
    wr(`SRRE_A_PSW, 32'h0000_00c4);
    // byte then word push and pop behind the escape prefix
    for (int k = 0; k < 2; k++) begin
      v = k ? {16'h0, 16'($urandom)} : {24'h0, 8'($urandom)};
      wr(`SRRE_A_SP, 32'h0000_0020);
      wr(`SRRE_A_OPND, v);
      ins(`SRRE_OP_ESC);
      ins(`SRRE_OP_PUSHR);
      ins({4'h0, k ? `SRRE_SUB_WORD : `SRRE_SUB_BYTE});
      rd(`SRRE_A_SP, 32'(33 + k));
      wr(`SRRE_A_RADR, 32'(33 + k));
      rd(`SRRE_A_RDAT, {24'h0, v[7:0]});
      wr(`SRRE_A_RADR, 32'h0000_0021);
      rd(`SRRE_A_RDAT, {24'h0, k ? v[15:8] : v[7:0]});
      wr(`SRRE_A_OPND, 32'hffff_ffff);
      ins(`SRRE_OP_ESC);
      ins(`SRRE_OP_POPR);
      ins({4'h0, k ? `SRRE_SUB_WORD : `SRRE_SUB_BYTE});
      rd(`SRRE_A_OPND, v);
      rd(`SRRE_A_SP, 32'h0000_0020);
    end
    // without the prefix: refused in binary mode, taken in source mode
    wr(`SRRE_A_SP, 32'h0000_0030);
    ins(`SRRE_OP_PUSHR);
    ins({4'h0, `SRRE_SUB_BYTE});
    rd(`SRRE_A_SP, 32'h0000_0030);
    wr(`SRRE_A_CFG, 32'h0000_0001);
    ins(`SRRE_OP_PUSHR);
    ins({4'h0, `SRRE_SUB_BYTE});
    rd(`SRRE_A_SP, 32'h0000_0031);
    wr(`SRRE_A_CFG, 32'h0000_0000);
    // subroutine return keeps the upper address byte
    ram(8'h0a, 8'h01);
    ram(8'h0b, 8'h23);
    wr(`SRRE_A_SP, 32'h0000_000b);
    wr(`SRRE_A_PC, 32'h005a_0000);
    ins(`SRRE_OP_RET);
    rd(`SRRE_A_SP, 32'h0000_0009);
    rd(`SRRE_A_PC, 32'h005a_0123);
    // short interrupt return with an interrupt pending
    wr(`SRRE_A_SP, 32'h0000_000b);
    wr(`SRRE_A_EXTENDED_STATUS_WORD, 32'h0000_0022);
    pend_req <= 1'b1;
    ins(`SRRE_OP_INTERRUPT_RETURN_OP);
    rd(`SRRE_A_SP, 32'h0000_0009);
    rd(`SRRE_A_PC, 32'h00ff_0123);
    rd(`SRRE_A_EXTENDED_STATUS_WORD, 32'h0000_0022);
    @(negedge clk_sys_i);
    chk("rearm", 32'd1, 32'(rearm_cnt));
    chk("ack", 32'd0, {31'h0, interrupt_frame_size_bit_ack_o});
    ins(`SRRE_OP_RL);
    rd(`SRRE_A_SP, 32'h0000_0009);
    pend_req <= 1'b0;
    @(negedge clk_sys_i);
    chk("ack", 32'd1, {31'h0, interrupt_frame_size_bit_ack_o});
    // long frame: pc low, mid, high, then extended status
    wr(`SRRE_A_CFG, 32'h0000_0004);
    ram(8'h0d, 8'h23);
    ram(8'h0c, 8'h01);
    ram(8'h0b, 8'h7c);
    ram(8'h0a, 8'h5a);
    wr(`SRRE_A_SP, 32'h0000_000d);
    ins(`SRRE_OP_INTERRUPT_RETURN_OP);
    rd(`SRRE_A_SP, 32'h0000_0009);
    rd(`SRRE_A_PC, 32'h007c_0123);
    rd(`SRRE_A_EXTENDED_STATUS_WORD, 32'h0000_005a);
    rd(`SRRE_A_PSW, 32'h0000_00c4);
    @(negedge clk_sys_i);
    chk("rearm", 32'd2, 32'(rearm_cnt));
    summarize();
  end
endmodule
